/* shared/dips_defs.svh */
// constants for the converter input port and phase strobe block
`ifndef DIPS_DEFS_SVH
`define DIPS_DEFS_SVH
`define DIPS_WORD_W        16
`define DIPS_MIDSCALE      16'h8000
`define DIPS_ADDR_W        32
`define DIPS_DATA_W        32
`define DIPS_OFF_CTRL      32'h0000_0000
`define DIPS_OFF_STATUS    32'h0000_0004
`define DIPS_OFF_STROBES   32'h0000_0008
`define DIPS_CTRL_REV      0
`define DIPS_CTRL_SYNC     1
`define DIPS_CTRL_ILV      2
`define DIPS_CTRL_MARK     3
`define DIPS_CTRL_EXTCLK   4
`define DIPS_CTRL_MASK     32'h0000_001f
`define DIPS_CTRL_RESET    32'h0000_0000
`define DIPS_CNT_W         16
`define DIPS_RESP_OKAY     2'h0
`define DIPS_RESP_SLVERR   2'h2
`endif

/* shared/dips_pkg.sv */
// types for the converter input port and phase strobe block
package dips_pkg;
  typedef struct packed {
    logic [15:0] first_word;
    logic [15:0] second_word;
    logic        second_mark;
  } dips_pair_s;

  typedef struct packed {
    logic [15:0] first_true;
    logic [15:0] first_comp;
    logic [15:0] second_true;
    logic [15:0] second_comp;
  } dips_out_s;

  typedef enum logic [2:0] {
    DIPS_IDLE = 3'h1,
    DIPS_RESP = 3'h2,
    DIPS_HOLD = 3'h4
  } dips_bus_e;
endpackage : dips_pkg

/* logic/dips_top.sv */
// input port front end: sample capture, coding, phase strobe, register slave
`timescale 1ns/100ps
`include "dips_defs.svh"
module dips_top
  import dips_pkg::*;
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  // sample inputs
  input  wire logic [`DIPS_WORD_W-1:0]  first_channel_word,
  input  wire logic [`DIPS_WORD_W-1:0]  second_channel_word,
  input  wire logic                     transmit_gate,
  input  wire logic                     phase_strobe,
  // converter side
  output logic      [63:0]              conv_out,
  output logic                          conv_valid,
  input  wire logic                     conv_ready,
  output logic                          second_marker_o,
  output logic                          second_marker_oe,
  output logic                          phase_acc_clear,
  output logic                          div_phase_set,
  // axi4-lite slave
  input  wire logic [`DIPS_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [`DIPS_DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic      [1:0]               s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`DIPS_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic      [`DIPS_DATA_W-1:0]  s_axi_rdata,
  output logic      [1:0]               s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  // sys_clk stands for the data-rate clock; the sample clock domain is outside
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [`DIPS_CNT_W-1:0] strobe_cnt_r, strobe_cnt_nxt;
  logic sync1_r, sync2_r, sync3_r, gate_r;
  logic acc_clr_r, acc_clr_nxt, div_set_r, div_set_nxt;
  logic phase_sel_r, phase_sel_nxt;
  logic rev_bus, sync_sel, ilv_mode, mark_en, ext_clk;

  assign rev_bus  = ctrl_r[`DIPS_CTRL_REV];
  assign sync_sel = ctrl_r[`DIPS_CTRL_SYNC];
  assign ilv_mode = ctrl_r[`DIPS_CTRL_ILV];
  assign mark_en  = ctrl_r[`DIPS_CTRL_MARK];
  assign ext_clk  = ctrl_r[`DIPS_CTRL_EXTCLK];

  // strobe: sync2 is the first point where level or edge is looked at
  always_comb begin
    acc_clr_nxt    = sync2_r;
    div_set_nxt    = sync_sel & ext_clk & sync2_r & ~sync3_r;
    strobe_cnt_nxt = strobe_cnt_r;
    if (sync2_r & ~sync3_r) begin
      strobe_cnt_nxt = strobe_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r      <= 1'b0;
      sync2_r      <= 1'b0;
      sync3_r      <= 1'b0;
      acc_clr_r    <= 1'b0;
      div_set_r    <= 1'b0;
      strobe_cnt_r <= '0;
    end else begin
      sync1_r      <= phase_strobe;
      sync2_r      <= sync1_r;
      sync3_r      <= sync2_r;
      acc_clr_r    <= acc_clr_nxt;
      div_set_r    <= div_set_nxt;
      strobe_cnt_r <= strobe_cnt_nxt;
    end
  end
  assign phase_acc_clear = acc_clr_r;
  assign div_phase_set   = div_set_r;

  // capture and coding
  logic [15:0] word_b;
  dips_pair_s  in_pair;
  logic        in_valid, in_ready;
  logic [15:0] code_a, code_b;

  always_comb begin
    for (int i = 0; i < `DIPS_WORD_W; i++) begin
      word_b[i] = rev_bus ? second_channel_word[`DIPS_WORD_W-1-i] : second_channel_word[i];
    end
  end

  always_comb begin
    phase_sel_nxt = phase_sel_r;
    if (transmit_gate & ~gate_r) begin
      phase_sel_nxt = 1'b1; // word at gate rise is first channel, so the next word is second
    end else if (transmit_gate) begin
      // pins have no back-pressure, so the channel order advances every cycle
      phase_sel_nxt = ~phase_sel_r;
    end
    if (!ilv_mode) begin
      phase_sel_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r      <= 1'b0;
      phase_sel_r <= 1'b0;
    end else begin
      gate_r      <= transmit_gate;
      phase_sel_r <= phase_sel_nxt;
    end
  end

  // in interleaved mode, words ride the first bus; second-channel word flagged
  logic ilv_second;
  assign ilv_second = ilv_mode & ~(transmit_gate & ~gate_r) & phase_sel_r;

  always_comb begin
    code_a = first_channel_word;
    code_b = word_b;
    if (ilv_mode) begin
      code_a = first_channel_word;
      code_b = first_channel_word;
    end
    if (!transmit_gate) begin
      code_a = `DIPS_MIDSCALE;
      code_b = `DIPS_MIDSCALE;
    end
    in_pair.first_word  = code_a;
    in_pair.second_word = code_b;
    in_pair.second_mark = ilv_second & transmit_gate;
  end
  assign in_valid = 1'b1;

  // two-entry buffer; with a stalled converter side, words arriving once both entries are full are dropped
  dips_pair_s buf_r [2];
  dips_pair_s buf0_nxt, buf1_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic       do_push, do_pop;
  assign in_ready = (cnt_r != 2'h2);
  assign do_push  = in_valid & in_ready;
  assign do_pop   = (cnt_r != 2'h0) & conv_ready;

  always_comb begin
    buf0_nxt = buf_r[0];
    buf1_nxt = buf_r[1];
    cnt_nxt  = cnt_r + {1'b0, do_push} - {1'b0, do_pop};
    if (do_pop) begin
      buf0_nxt = buf_r[1];
    end
    if (do_push) begin
      if (cnt_r == 2'h0 || (cnt_r == 2'h1 && do_pop)) begin
        buf0_nxt = in_pair;
      end else begin
        buf1_nxt = in_pair;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      cnt_r    <= 2'h0;
    end else begin
      buf_r[0] <= buf0_nxt;
      buf_r[1] <= buf1_nxt;
      cnt_r    <= cnt_nxt;
    end
  end

  // straight binary: true output follows code, complementary its inverse
  dips_out_s out_nxt;
  logic [63:0] out_r;
  logic        vld_r, mark_r, mark_oe_r;
  always_comb begin
    out_nxt.first_true  = buf0_nxt.first_word;
    out_nxt.first_comp  = ~buf0_nxt.first_word;
    out_nxt.second_true = buf0_nxt.second_word;
    out_nxt.second_comp = ~buf0_nxt.second_word;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r     <= {`DIPS_MIDSCALE, ~`DIPS_MIDSCALE, `DIPS_MIDSCALE, ~`DIPS_MIDSCALE};
      vld_r     <= 1'b0;
      mark_r    <= 1'b0;
      mark_oe_r <= 1'b0;
    end else begin
      out_r     <= out_nxt;
      vld_r     <= (cnt_nxt != 2'h0);
      mark_r    <= mark_en & ilv_mode & buf0_nxt.second_mark;
      mark_oe_r <= mark_en & ilv_mode;
    end
  end
  // output fed from buf0_nxt so conv_out mirrors the buffer head from the first clock after reset
  assign conv_out         = out_r;
  assign conv_valid       = vld_r;
  assign second_marker_o  = mark_r;
  assign second_marker_oe = mark_oe_r;

  // axi4-lite slave, single outstanding read and write
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic [31:0] awa_r, awa_nxt, wd_r, wd_nxt, rd_r, rd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic [1:0]  br_r, br_nxt, rr_r, rr_nxt;
  logic        wr_go;
  logic        awrdy_r, awrdy_nxt, wrdy_r, wrdy_nxt, arrdy_r, arrdy_nxt;

  assign wr_go = aw_got_r & w_got_r & ~bv_r;
  always_comb begin
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awa_nxt    = awa_r;
    wd_nxt     = wd_r;
    ws_nxt     = ws_r;
    bv_nxt     = bv_r;
    br_nxt     = br_r;
    ctrl_nxt   = ctrl_r;
    rv_nxt     = rv_r;
    rd_nxt     = rd_r;
    rr_nxt     = rr_r;
    if (s_axi_awvalid & ~aw_got_r) begin
      aw_got_nxt = 1'b1;
      awa_nxt    = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~w_got_r) begin
      w_got_nxt = 1'b1;
      wd_nxt    = s_axi_wdata;
      ws_nxt    = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bv_nxt     = 1'b1;
      br_nxt     = `DIPS_RESP_OKAY;
      if (awa_r[7:2] == 6'(`DIPS_OFF_CTRL >> 2)) begin
        for (int b = 0; b < 4; b++) begin
          if (ws_r[b]) begin
            ctrl_nxt[b*8 +: 8] = wd_r[b*8 +: 8];
          end
        end
        ctrl_nxt = ctrl_nxt & `DIPS_CTRL_MASK;
      end else if (awa_r[7:2] != 6'(`DIPS_OFF_STATUS >> 2) && awa_r[7:2] != 6'(`DIPS_OFF_STROBES >> 2)) begin
        br_nxt = `DIPS_RESP_SLVERR;
      end
    end
    if (bv_r & s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    if (rv_r & s_axi_rready) begin
      rv_nxt = 1'b0;
    end else if (s_axi_arvalid & ~rv_r) begin
      rv_nxt = 1'b1;
      rr_nxt = `DIPS_RESP_OKAY;
      case (s_axi_araddr[7:2])
        6'(`DIPS_OFF_CTRL >> 2):    rd_nxt = ctrl_r;
        6'(`DIPS_OFF_STATUS >> 2):  rd_nxt = {26'h0, cnt_r, mark_r, gate_r, phase_sel_r, sync2_r};
        6'(`DIPS_OFF_STROBES >> 2): rd_nxt = {16'h0, strobe_cnt_r};
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = `DIPS_RESP_SLVERR;
        end
      endcase
    end
    awrdy_nxt = ~aw_got_nxt;
    wrdy_nxt  = ~w_got_nxt;
    arrdy_nxt = ~rv_nxt;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awa_r    <= 32'h0;
      wd_r     <= 32'h0;
      ws_r     <= 4'h0;
      bv_r     <= 1'b0;
      br_r     <= 2'h0;
      ctrl_r   <= `DIPS_CTRL_RESET;
      rv_r     <= 1'b0;
      rd_r     <= 32'h0;
      rr_r     <= 2'h0;
      awrdy_r  <= 1'b1;
      wrdy_r   <= 1'b1;
      arrdy_r  <= 1'b1;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awa_r    <= awa_nxt;
      wd_r     <= wd_nxt;
      ws_r     <= ws_nxt;
      bv_r     <= bv_nxt;
      br_r     <= br_nxt;
      ctrl_r   <= ctrl_nxt;
      rv_r     <= rv_nxt;
      rd_r     <= rd_nxt;
      rr_r     <= rr_nxt;
      awrdy_r  <= awrdy_nxt;
      wrdy_r   <= wrdy_nxt;
      arrdy_r  <= arrdy_nxt;
    end
  end
  // awready and wready mirror the capture flags and arready the read valid, each in its own flop, so no port is combinational
  assign s_axi_awready = awrdy_r;
  assign s_axi_wready  = wrdy_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;
  assign s_axi_arready = arrdy_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;
endmodule : dips_top

/* test/dips_top_asserts.sv */
// concurrent checks on the ports of the input port front end
`timescale 1ns/100ps
module dips_top_asserts (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_n,
  // sample side
  input wire logic        transmit_gate,
  input wire logic        phase_strobe,
  // converter side
  input wire logic [63:0] conv_out,
  input wire logic        conv_valid,
  input wire logic        conv_ready,
  input wire logic        phase_acc_clear,
  input wire logic        div_phase_set,
  // write response
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_first_comp; conv_valid |-> conv_out[47:32] == ~conv_out[63:48]; endproperty
  a_first_comp: assert property (p_first_comp) else $error("first comp not inverse of true");
  property p_second_comp; conv_valid |-> conv_out[15:0] == ~conv_out[31:16]; endproperty
  a_second_comp: assert property (p_second_comp) else $error("second comp not inverse of true");
  // a stalled head must not move, or the converter would lose a word
  property p_stall_hold; conv_valid && !conv_ready |=> conv_valid && $stable(conv_out); endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("head word moved under stall");
  property p_gate_mid; (!transmit_gate && conv_ready)[*3] |=> conv_out == 64'h8000_7fff_8000_7fff; endproperty
  a_gate_mid: assert property (p_gate_mid) else $error("gate low but output not midscale");
  property p_strobe_clear; $rose(phase_strobe) |-> ##[2:3] phase_acc_clear; endproperty
  a_strobe_clear: assert property (p_strobe_clear) else $error("strobe did not clear phase");
  property p_clear_drop; $fell(phase_strobe) |-> ##[2:3] !phase_acc_clear; endproperty
  a_clear_drop: assert property (p_clear_drop) else $error("phase clear stuck after strobe");
  property p_set_pulse; div_phase_set |=> !div_phase_set; endproperty
  a_set_pulse: assert property (p_set_pulse) else $error("phase set longer than one cycle");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
endmodule : dips_top_asserts

/* test/dips_src_model.sv */
// far-side sample source: parallel words, gate and phase strobe
`timescale 1ns/100ps
module dips_src_model (
  // clock
  input wire logic  sys_clk,
  // sample pins
  output logic [15:0] first_channel_word,
  output logic [15:0] second_channel_word,
  output logic        transmit_gate,
  output logic        phase_strobe
);
  initial begin
    first_channel_word = 16'h0000;
    second_channel_word = 16'h0000;
    transmit_gate = 1'b0;
    phase_strobe = 1'b0;
  end
  // pins change just after the data-rate edge, so capture never races
  task put(input logic [15:0] a, input logic [15:0] b, input logic g, input logic s);
    @(posedge sys_clk);
    first_channel_word <= a;
    second_channel_word <= b;
    transmit_gate <= g;
    phase_strobe <= s;
  endtask : put
endmodule : dips_src_model

/* test/tb_dac_input_port_phase_sync.sv */
// self-checking bench for the input port front end
`timescale 1ns/100ps
`include "dips_defs.svh"
module tb_dac_input_port_phase_sync;
  logic        sys_clk, rst_n, conv_ready;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  wire  [15:0] first_channel_word, second_channel_word;
  wire         transmit_gate, phase_strobe, conv_valid, second_marker_o, second_marker_oe;
  wire         phase_acc_clear, div_phase_set, s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire         s_axi_arready, s_axi_rvalid;
  wire  [63:0] conv_out;
  wire  [1:0]  s_axi_bresp, s_axi_rresp;
  wire  [31:0] s_axi_rdata;
  int          failures, total_checks, cyc;
  dips_src_model src (.sys_clk, .first_channel_word, .second_channel_word, .transmit_gate, .phase_strobe);
  dips_top dut (.sys_clk, .rst_n, .first_channel_word, .second_channel_word, .transmit_gate, .phase_strobe,
    .conv_out, .conv_valid, .conv_ready, .second_marker_o, .second_marker_oe, .phase_acc_clear, .div_phase_set,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      summarize();
    end
  end
  function automatic logic [63:0] ex(input logic [15:0] a, input logic [15:0] b);
    return {a, ~a, b, ~b};
  endfunction : ex
  task chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge sys_clk);
      aw_t = s_axi_awvalid & s_axi_awready;
      w_t = s_axi_wvalid & s_axi_wready;
      b_t = s_axi_bvalid;
      if (b_t) chk({62'h0, s_axi_bresp}, {62'h0, er});
      @(posedge sys_clk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
  endtask : wr
  task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic a_t, r_t;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge sys_clk);
      a_t = s_axi_arvalid & s_axi_arready;
      r_t = s_axi_rvalid;
      if (r_t) chk({30'h0, s_axi_rresp, s_axi_rdata}, {30'h0, er, ed});
      @(posedge sys_clk);
      if (a_t) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd
  task t_regs;
    rd(`DIPS_OFF_CTRL, `DIPS_CTRL_RESET, `DIPS_RESP_OKAY);
    wr(`DIPS_OFF_CTRL, 32'hffff_ffff, `DIPS_RESP_OKAY);
    rd(`DIPS_OFF_CTRL, `DIPS_CTRL_MASK, `DIPS_RESP_OKAY);
    wr(`DIPS_OFF_STATUS, 32'h0000_0000, `DIPS_RESP_OKAY);
    wr(32'h0000_0010, 32'h0000_0000, `DIPS_RESP_SLVERR);
    rd(32'h0000_0010, 32'h0000_0000, `DIPS_RESP_SLVERR);
    wr(`DIPS_OFF_CTRL, 32'h0000_0000, `DIPS_RESP_OKAY);
    $display("t_regs done");
  endtask : t_regs
  task t_codes;
    logic [15:0] tab [4];
    tab = '{16'hffff, 16'h0000, 16'h1234, 16'h8001};
    for (int i = 0; i < 4; i++) begin
      src.put(tab[i], tab[3-i], 1'b1, 1'b0);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(conv_out, ex(tab[i], tab[3-i]));
    end
    wr(`DIPS_OFF_CTRL, 32'h0000_0001, `DIPS_RESP_OKAY);
    src.put(16'h5a5a, 16'h00f1, 1'b1, 1'b0);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(conv_out, ex(16'h5a5a, 16'h8f00));
    wr(`DIPS_OFF_CTRL, 32'h0000_0000, `DIPS_RESP_OKAY);
    src.put(16'h5a5a, 16'h00f1, 1'b0, 1'b0);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(conv_out, ex(`DIPS_MIDSCALE, `DIPS_MIDSCALE));
    rd(`DIPS_OFF_STATUS, 32'h0000_0010, `DIPS_RESP_OKAY);
    $display("t_codes done");
  endtask : t_codes
  task t_stall;
    src.put(16'h1111, 16'h1111, 1'b1, 1'b0);
    src.put(16'h2222, 16'h2222, 1'b1, 1'b0);
    conv_ready <= 1'b0;
    src.put(16'h3333, 16'h3333, 1'b1, 1'b0);
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(conv_out, ex(16'h1111, 16'h1111));
    chk({63'h0, conv_valid}, 64'h1);
    @(posedge sys_clk);
    conv_ready <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(conv_out, ex(16'h2222, 16'h2222));
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(conv_out, ex(16'h3333, 16'h3333));
    $display("t_stall done");
  endtask : t_stall
  task t_strobe;
    logic [31:0] cv [2];
    int n;
    cv = '{32'h0000_0012, 32'h0000_0000};
    for (int i = 0; i < 2; i++) begin
      wr(`DIPS_OFF_CTRL, cv[i], `DIPS_RESP_OKAY);
      src.put(16'h0000, 16'h0000, 1'b1, 1'b1);
      n = 0;
      repeat (6) begin
        @(negedge sys_clk);
        if (div_phase_set === 1'b1) n++;
      end
      chk({63'h0, phase_acc_clear}, 64'h1);
      chk(64'(n), 64'(1 - i));
      src.put(16'h0000, 16'h0000, 1'b1, 1'b0);
      repeat (6) @(posedge sys_clk);
      @(negedge sys_clk);
      chk({63'h0, phase_acc_clear}, 64'h0);
    end
    rd(`DIPS_OFF_STROBES, 32'h0000_0002, `DIPS_RESP_OKAY);
    $display("t_strobe done");
  endtask : t_strobe
  task t_ilv;
    wr(`DIPS_OFF_CTRL, 32'h0000_000c, `DIPS_RESP_OKAY);
    src.put(16'h0000, 16'h0000, 1'b0, 1'b0);
    src.put(16'haaa1, 16'h0000, 1'b1, 1'b0);
    src.put(16'hbbb2, 16'h0000, 1'b1, 1'b0);
    @(negedge sys_clk);
    chk({62'h0, second_marker_oe, second_marker_o}, 64'h2);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({62'h0, second_marker_oe, second_marker_o}, 64'h3);
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk({62'h0, second_marker_oe, second_marker_o}, 64'h2);
    chk(conv_out, ex(16'hbbb2, 16'hbbb2));
    wr(`DIPS_OFF_CTRL, 32'h0000_0000, `DIPS_RESP_OKAY);
    $display("t_ilv done");
  endtask : t_ilv
  task summarize;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  initial begin
    rst_n = 1'b0;
    conv_ready = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge sys_clk);
    chk({63'h0, conv_valid}, 64'h0);
    rst_n <= 1'b1;
    t_regs();
    t_codes();
    t_stall();
    t_strobe();
    t_ilv();
    summarize();
  end
endmodule : tb_dac_input_port_phase_sync
bind dips_top dips_top_asserts u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .transmit_gate(transmit_gate),
  .phase_strobe(phase_strobe), .conv_out(conv_out), .conv_valid(conv_valid), .conv_ready(conv_ready),
  .phase_acc_clear(phase_acc_clear), .div_phase_set(div_phase_set), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));
